// file: verilog/hrr_sensor.sv
// sensor end: command intake, measurement sequencing and result readout
`timescale 1ns/10ps
`default_nettype none
module hrr_sensor #(
	parameter int PERIOD_CYC [5] = hrr_pkg::PER_PERIOD_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	hrr_link_if.dev link,
	input wire logic meas_done_in,
	input wire logic [15:0] temp_in,
	input wire logic [15:0] hum_in,
	output logic meas_start_out,
	output hrr_pkg::hrr_rep_t meas_rep_out,
	output logic periodic_out,
	output hrr_pkg::hrr_rate_t rate_out,
	output logic result_valid_out
);
	import hrr_pkg::*;

	for (genvar g = 0; g < 5; g++) begin : g_chk
		if (PERIOD_CYC[g] < 2) begin : g_bad
			$error("period too short");
		end
	end

	typedef enum logic [7:0] {
		D_IDLE = 8'b00000001,
		D_ADDR = 8'b00000010,
		D_RX = 8'b00000100,
		D_ACKW = 8'b00001000,
		D_ACKR = 8'b00010000,
		D_STRETCH = 8'b00100000,
		D_TX = 8'b01000000,
		D_TXACK = 8'b10000000
	} hrr_dstate_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		hrr_dstate_t st;
		logic [3:0] bitc;
		logic [2:0] bytec;
		logic [7:0] sh;
		logic [7:0] cmd_hi;
		logic sda_drv;
		logic scl_drv;
		logic mack;
		logic stretch_mode;
		logic periodic;
		logic busy;
		logic valid;
		logic start;
		hrr_rep_t rep;
		hrr_rate_t rate;
		logic [31:0] timer;
		logic [15:0] temp;
		logic [15:0] hum;
		logic [15:0] tx_t;
		logic [15:0] tx_h;
	} hrr_dev_s_t;

	localparam hrr_dev_s_t S_RST = '{st: D_IDLE, rep: REP_HIGH, rate: RATE_0P5, default: '0};

	hrr_dev_s_t s;
	hrr_dev_s_t next_s;

	function automatic logic [7:0] pick_byte(input logic [2:0] i, input logic [15:0] t, input logic [15:0] h);
		case (i)
			3'h0: pick_byte = t[15:8];
			3'h1: pick_byte = t[7:0];
			3'h2: pick_byte = hrr_crc8(t);
			3'h3: pick_byte = h[15:8];
			3'h4: pick_byte = h[7:0];
			default: pick_byte = hrr_crc8(h);
		endcase
	endfunction

	always_comb begin
		logic rise;
		logic fall;
		logic start_c;
		logic stop_c;
		logic [15:0] cmd;
		logic [7:0] b;
		rise = 1'b0;
		fall = 1'b0;
		start_c = 1'b0;
		stop_c = 1'b0;
		cmd = '0;
		b = '0;
		next_s = s;
		next_s.scl_s1 = link.scl;
		next_s.scl_s2 = s.scl_s1;
		next_s.scl_d = s.scl_s2;
		next_s.sda_s1 = link.sda;
		next_s.sda_s2 = s.sda_s1;
		next_s.sda_d = s.sda_s2;
		next_s.start = 1'b0;
		rise = s.scl_s2 && !s.scl_d;
		fall = !s.scl_s2 && s.scl_d;
		start_c = s.scl_s2 && s.scl_d && s.sda_d && !s.sda_s2;
		stop_c = s.scl_s2 && s.scl_d && !s.sda_d && s.sda_s2;
		cmd = {s.cmd_hi, s.sh};
		if (start_c) begin
			next_s.st = D_ADDR;
			next_s.bitc = '0;
			next_s.sda_drv = 1'b0;
			next_s.scl_drv = 1'b0;
		end else if (stop_c) begin
			next_s.st = D_IDLE;
			next_s.sda_drv = 1'b0;
			next_s.scl_drv = 1'b0;
		end else begin
			case (s.st)
				D_ADDR, D_RX: begin
					if (rise && s.bitc < 4'h8) begin
						next_s.sh = {s.sh[6:0], s.sda_s2};
						next_s.bitc = s.bitc + 4'h1;
					end else if (fall && s.bitc == 4'h8) begin
						next_s.bitc = '0;
						if (s.st == D_ADDR) begin
							next_s.bytec = '0;
							if (s.sh[7:1] != DEV_ADDR) begin
								next_s.st = D_IDLE;
							end else if (!s.sh[0]) begin
								next_s.sda_drv = 1'b1;
								next_s.st = D_ACKW;
							end else if (s.valid || (s.stretch_mode && s.busy)) begin
								next_s.sda_drv = 1'b1;
								next_s.st = D_ACKR;
							end else begin
								next_s.st = D_IDLE;
							end
						end else begin
							next_s.sda_drv = 1'b1;
							next_s.st = D_ACKW;
							if (s.bytec == 3'h0) begin
								next_s.cmd_hi = s.sh;
								next_s.bytec = 3'h1;
							end else begin
								next_s.bytec = 3'h0;
								if (cmd == CMD_BREAK) begin
									// running measurement keeps busy and still completes
									next_s.periodic = 1'b0;
									next_s.stretch_mode = 1'b0;
								end
								for (int r = 0; r < 3; r++) begin
									if (cmd == {SS_STR_MSB, SS_STR_LSB[r]} || cmd == {SS_NOSTR_MSB, SS_NOSTR_LSB[r]}) begin
										next_s.periodic = 1'b0;
										next_s.stretch_mode = (cmd[15:8] == SS_STR_MSB);
										next_s.rep = hrr_rep_t'(2'(r));
										next_s.valid = 1'b0;
										if (!s.busy) begin
											next_s.start = 1'b1;
											next_s.busy = 1'b1;
										end
									end
									for (int k = 0; k < 5; k++) begin
										if (cmd == {PER_MSB[k], PER_LSB[k][r]}) begin
											next_s.periodic = 1'b1;
											next_s.stretch_mode = 1'b0;
											next_s.rep = hrr_rep_t'(2'(r));
											next_s.rate = hrr_rate_t'(3'(k));
											next_s.timer = 32'(PERIOD_CYC[k] - 1);
											if (!s.busy) begin
												next_s.start = 1'b1;
												next_s.busy = 1'b1;
											end
										end
									end
								end
							end
						end
					end
				end
				D_ACKW: begin
					if (fall) begin
						next_s.sda_drv = 1'b0;
						next_s.st = D_RX;
					end
				end
				D_ACKR, D_STRETCH: begin
					if (s.valid && (fall || s.st == D_STRETCH)) begin
						next_s.tx_t = s.temp;
						next_s.tx_h = s.hum;
						next_s.valid = 1'b0;
						next_s.bytec = '0;
						next_s.sh = s.temp[15:8];
						next_s.sda_drv = !s.temp[15];
						next_s.scl_drv = 1'b0;
						next_s.st = D_TX;
					end else if (fall) begin
						next_s.sda_drv = 1'b0;
						next_s.scl_drv = 1'b1;
						next_s.st = D_STRETCH;
					end
				end
				D_TX: begin
					if (fall) begin
						if (s.bitc == 4'h7) begin
							next_s.sda_drv = 1'b0;
							next_s.st = D_TXACK;
						end else begin
							next_s.sh = {s.sh[6:0], 1'b0};
							next_s.sda_drv = !s.sh[6];
							next_s.bitc = s.bitc + 4'h1;
						end
					end
				end
				D_TXACK: begin
					if (rise) begin
						next_s.mack = !s.sda_s2;
					end else if (fall) begin
						next_s.bitc = '0;
						if (s.mack && s.bytec < 3'(N_RES_BYTES - 1)) begin
							b = pick_byte(s.bytec + 3'h1, s.tx_t, s.tx_h);
							next_s.sh = b;
							next_s.sda_drv = !b[7];
							next_s.bytec = s.bytec + 3'h1;
							next_s.st = D_TX;
						end else begin
							next_s.st = D_IDLE;
						end
					end
				end
				default: begin
					next_s.sda_drv = 1'b0;
					next_s.scl_drv = 1'b0;
				end
			endcase
		end
		// acquisition engine runs after link handling so a result set beats a consume
		if (s.periodic) begin
			if (s.timer == '0) begin
				next_s.timer = 32'(PERIOD_CYC[s.rate] - 1);
				if (!s.busy) begin
					next_s.start = 1'b1;
					next_s.busy = 1'b1;
				end
			end else begin
				next_s.timer = s.timer - 32'h1;
			end
		end
		if (meas_done_in && s.busy) begin
			next_s.busy = 1'b0;
			next_s.valid = 1'b1;
			next_s.temp = temp_in;
			next_s.hum = hum_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s <= S_RST;
		end else begin
			s <= next_s;
		end
	end

	assign link.dev_scl_out = 1'b0;
	assign link.dev_sda_out = 1'b0;
	assign link.dev_scl_oe = s.scl_drv;
	assign link.dev_sda_oe = s.sda_drv;
	assign meas_start_out = s.start;
	assign meas_rep_out = s.rep;
	assign periodic_out = s.periodic;
	assign rate_out = s.rate;
	assign result_valid_out = s.valid;
endmodule
`default_nettype wire

// file: verilog/hrr_pkg.sv
// shared constants, types and checksum for the result readout link
package hrr_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h44;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int SCL_PERIOD_NS = 800;
	localparam int SCL_QTR_CYC = (SCL_PERIOD_NS / (4 * CLK_PERIOD_NS)) < 1 ? 1 : SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int N_RES_BYTES = 6;
	localparam logic [7:0] SS_STR_MSB = 8'h2c;
	localparam logic [7:0] SS_NOSTR_MSB = 8'h24;
	localparam logic [7:0] SS_STR_LSB [3] = '{8'h06, 8'h0d, 8'h10};
	localparam logic [7:0] SS_NOSTR_LSB [3] = '{8'h00, 8'h0b, 8'h16};
	localparam logic [7:0] PER_MSB [5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27};
	localparam logic [7:0] PER_LSB [5][3] = '{'{8'h32, 8'h24, 8'h2f}, '{8'h30, 8'h26, 8'h2d},
		'{8'h36, 8'h20, 8'h2b}, '{8'h34, 8'h22, 8'h29}, '{8'h37, 8'h21, 8'h2a}};
	localparam logic [15:0] CMD_BREAK = 16'h30a5;
	localparam int PER_PERIOD_MS [5] = '{2000, 1000, 500, 250, 100};
	localparam int PER_PERIOD_CYC [5] = '{PER_PERIOD_MS[0] * CYC_PER_MS, PER_PERIOD_MS[1] * CYC_PER_MS,
		PER_PERIOD_MS[2] * CYC_PER_MS, PER_PERIOD_MS[3] * CYC_PER_MS, PER_PERIOD_MS[4] * CYC_PER_MS};
	localparam logic [7:0] CRC_POLY = 8'h31;
	localparam logic [7:0] CRC_INIT = 8'hff;

	typedef enum logic [1:0] {REP_HIGH = 2'h0, REP_MED = 2'h1, REP_LOW = 2'h2} hrr_rep_t;
	typedef enum logic [2:0] {RATE_0P5 = 3'h0, RATE_1 = 3'h1, RATE_2 = 3'h2, RATE_4 = 3'h3, RATE_10 = 3'h4} hrr_rate_t;

	function automatic logic [7:0] hrr_crc8(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage

// file: verilog/hrr_link_if.sv
// open-drain two-wire link between the sensor end and the master end
`timescale 1ns/10ps
`default_nettype none
interface hrr_link_if;
	logic scl;
	logic sda;
	logic dev_scl_out;
	logic dev_scl_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic mst_scl_out;
	logic mst_scl_oe;
	logic mst_sda_out;
	logic mst_sda_oe;

	// pull-up wins unless someone drives low
	assign scl = !((dev_scl_oe && !dev_scl_out) || (mst_scl_oe && !mst_scl_out));
	assign sda = !((dev_sda_oe && !dev_sda_out) || (mst_sda_oe && !mst_sda_out));

	modport dev (input scl, input sda, output dev_scl_out, output dev_scl_oe, output dev_sda_out, output dev_sda_oe);
	modport mst (input scl, input sda, output mst_scl_out, output mst_scl_oe, output mst_sda_out, output mst_sda_oe);
endinterface
`default_nettype wire

// file: verilog/hrr_master.sv
// master end: drives the serial clock, writes commands, reads results
`timescale 1ns/10ps
`default_nettype none
module hrr_master (
	input wire logic clk_in,
	input wire logic rst_n_in,
	hrr_link_if.mst link,
	input wire logic cmd_valid_in,
	input wire logic [15:0] cmd_code_in,
	input wire logic rd_valid_in,
	input wire logic [2:0] rd_count_in,
	output logic busy_out,
	output logic done_out,
	output logic nack_out,
	output logic [47:0] rx_data_out
);
	import hrr_pkg::*;

	typedef enum logic [3:0] {
		M_IDLE = 4'b0001,
		M_START = 4'b0010,
		M_BIT = 4'b0100,
		M_STOP = 4'b1000
	} hrr_mstate_t;

	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic sda_s1;
		logic sda_s2;
		hrr_mstate_t st;
		logic [7:0] div;
		logic [1:0] ph;
		logic [3:0] bitc;
		logic [2:0] bytec;
		logic [2:0] total;
		logic rw;
		logic [7:0] sh;
		logic [15:0] code;
		logic sda_drv;
		logic scl_drv;
		logic ackok;
		logic [47:0] rx;
		logic busy;
		logic done;
		logic nack;
	} hrr_mst_s_t;

	localparam hrr_mst_s_t S_RST = '{st: M_IDLE, default: '0};

	hrr_mst_s_t s;
	hrr_mst_s_t next_s;

	always_comb begin
		logic tick;
		logic tx;
		tick = 1'b0;
		tx = 1'b0;
		next_s = s;
		next_s.scl_s1 = link.scl;
		next_s.scl_s2 = s.scl_s1;
		next_s.sda_s1 = link.sda;
		next_s.sda_s2 = s.sda_s1;
		next_s.done = 1'b0;
		tick = (s.div == 8'(SCL_QTR_CYC - 1));
		next_s.div = tick ? 8'h0 : s.div + 8'h1;
		tx = (s.bytec == 3'h0) || !s.rw;
		if (s.st == M_IDLE) begin
			if (cmd_valid_in || rd_valid_in) begin
				next_s.st = M_START;
				next_s.ph = 2'h0;
				next_s.busy = 1'b1;
				next_s.nack = 1'b0;
				next_s.rw = !cmd_valid_in;
				next_s.code = cmd_code_in;
				next_s.rx = '0;
				if (rd_count_in == 3'h0) begin
					next_s.total = 3'h1;
				end else if (rd_count_in > 3'(N_RES_BYTES)) begin
					next_s.total = 3'(N_RES_BYTES);
				end else begin
					next_s.total = rd_count_in;
				end
			end
		end else if (tick) begin
			next_s.ph = s.ph + 2'h1;
			case (s.st)
				M_START: begin
					if (s.ph == 2'h0) begin
						next_s.sda_drv = 1'b0;
						next_s.scl_drv = 1'b0;
					end else if (s.ph == 2'h1) begin
						if (s.scl_s2 && s.sda_s2) begin
							next_s.sda_drv = 1'b1;
						end else begin
							next_s.ph = s.ph;
						end
					end else begin
						next_s.scl_drv = 1'b1;
						next_s.sh = {DEV_ADDR, s.rw};
						next_s.bitc = '0;
						next_s.bytec = '0;
						next_s.st = M_BIT;
						next_s.ph = 2'h0;
					end
				end
				M_BIT: begin
					case (s.ph)
						2'h0: begin
							if (s.bitc < 4'h8) begin
								next_s.sda_drv = tx && !s.sh[7];
							end else begin
								next_s.sda_drv = !tx && (s.bytec < s.total);
							end
						end
						2'h1: begin
							next_s.scl_drv = 1'b0;
						end
						2'h2: begin
							// a stretched clock holds the bit here until the sensor lets go
							if (!s.scl_s2) begin
								next_s.ph = s.ph;
							end else if (s.bitc == 4'h8) begin
								next_s.ackok = !s.sda_s2;
							end else if (!tx) begin
								next_s.sh = {s.sh[6:0], s.sda_s2};
							end
						end
						default: begin
							next_s.scl_drv = 1'b1;
							if (s.bitc < 4'h8) begin
								next_s.bitc = s.bitc + 4'h1;
								if (tx) begin
									next_s.sh = {s.sh[6:0], 1'b0};
								end
							end else begin
								next_s.bitc = '0;
								if (tx) begin
									if (!s.ackok) begin
										next_s.nack = 1'b1;
										next_s.st = M_STOP;
									end else if (s.rw) begin
										next_s.bytec = 3'h1;
									end else if (s.bytec == 3'h2) begin
										next_s.st = M_STOP;
									end else begin
										next_s.bytec = s.bytec + 3'h1;
										next_s.sh = (s.bytec == 3'h0) ? s.code[15:8] : s.code[7:0];
									end
								end else begin
									next_s.rx = {s.rx[39:0], s.sh};
									if (s.bytec == s.total) begin
										next_s.st = M_STOP;
									end else begin
										next_s.bytec = s.bytec + 3'h1;
									end
								end
							end
						end
					endcase
				end
				M_STOP: begin
					case (s.ph)
						2'h0: next_s.sda_drv = 1'b1;
						2'h1: next_s.scl_drv = 1'b0;
						2'h2: begin
							if (!s.scl_s2) begin
								next_s.ph = s.ph;
							end
						end
						default: begin
							next_s.sda_drv = 1'b0;
							next_s.st = M_IDLE;
							next_s.busy = 1'b0;
							next_s.done = 1'b1;
						end
					endcase
				end
				default: begin
					next_s.st = M_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s <= S_RST;
		end else begin
			s <= next_s;
		end
	end

	assign link.mst_scl_out = 1'b0;
	assign link.mst_sda_out = 1'b0;
	assign link.mst_scl_oe = s.scl_drv;
	assign link.mst_sda_oe = s.sda_drv;
	assign busy_out = s.busy;
	assign done_out = s.done;
	assign nack_out = s.nack;
	assign rx_data_out = s.rx;
endmodule
`default_nettype wire

// file: testbench/hrr_link_asserts.sv
// wire-level checks on the two-wire link between the two ends
`timescale 1ns/10ps
`default_nettype none
module hrr_link_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe
);
	import hrr_pkg::*;
	typedef struct packed {logic scl_q; logic sda_q; logic [3:0] bits; logic [3:0] nbyte; logic [7:0] sr;
		logic [7:0] hdr; logic [9:0] scnt;} hrr_mon_t;
	hrr_mon_t st;
	hrr_mon_t next_st;
	always_comb begin
		next_st = st;
		next_st.scl_q = scl;
		next_st.sda_q = sda;
		next_st.scnt = dev_scl_oe ? st.scnt + 10'h1 : 10'h0;
		if (scl && !st.scl_q) begin
			next_st.sr = {st.sr[6:0], sda};
			next_st.bits = (st.bits == 4'h8) ? 4'h0 : st.bits + 4'h1;
			next_st.nbyte = (st.bits == 4'h8) ? st.nbyte + 4'h1 : st.nbyte;
			if (st.bits == 4'h7 && st.nbyte == 4'h0) begin
				next_st.hdr = {st.sr[6:0], sda};
			end
		end
		// start condition restarts byte framing, so junk before it is harmless
		if (scl && st.scl_q && st.sda_q && !sda) begin
			next_st.bits = 4'h0;
			next_st.nbyte = 4'h0;
		end
		// idle lines sit high, so a zero here would fake a clock rise after reset
		if (!rst_n_in) begin
			next_st = '0;
			next_st.scl_q = 1'b1;
			next_st.sda_q = 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		st <= next_st;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	stretch_low_a: assert property (
		$rose(dev_scl_oe) |-> !$past(scl)) else $error("stretch began on a high clock");
	stretch_place_a: assert property (
		$rose(dev_scl_oe) |-> st.hdr == {DEV_ADDR, 1'b1} && st.nbyte == 4'h1 && st.bits == 4'h0)
		else $error("stretch outside read header ack");
	stretch_release_a: assert property (
		$fell(dev_scl_oe) |-> scl) else $error("clock still low after stretch");
	stretch_bound_a: assert property (
		dev_scl_oe |-> st.scnt < 10'd700) else $error("stretch outlived the measurement");
	sda_steady_a: assert property (
		$changed(dev_sda_oe) |-> !(scl && $past(scl))) else $error("data moved while clock high");
	ack_owner_a: assert property (
		$rose(scl) && st.bits == 4'h8 && dev_sda_oe |-> st.hdr[7:1] == DEV_ADDR && (st.nbyte == 4'h0 || !st.hdr[0]))
		else $error("sensor drove a master ack slot");
	write_ack_a: assert property (
		$rose(scl) && st.bits == 4'h8 && st.hdr == {DEV_ADDR, 1'b0} |-> dev_sda_oe) else $error("write byte not acked");
	nack_quiet_a: assert property (
		$rose(scl) && st.bits == 4'h8 && st.nbyte != 4'h0 && st.hdr[0] && sda |=> (!dev_sda_oe) [*6])
		else $error("sensor kept sending after nack");
	stretch_c: cover property ($rose(dev_scl_oe));
	abort_c: cover property ($rose(scl) && st.bits == 4'h8 && st.nbyte != 4'h0 && st.hdr[0] && sda);
	write_ack_c: cover property ($rose(scl) && st.bits == 4'h8 && !st.hdr[0] && dev_sda_oe);
endmodule
`default_nettype wire

// file: testbench/hrr_tb.sv
// self-checking bench joining the sensor end and the master end
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module humidity_temp_result_readout_tb;
	import hrr_pkg::*;
	typedef struct packed {logic nack; logic [2:0] n; logic [47:0] d;} hrr_note_t;
	// short periods keep the periodic runs brief
	localparam int SIM_PERIOD [5] = '{400, 300, 200, 100, 50};
	logic clk_in;
	logic rst_n_in;
	logic cmd_valid_in;
	logic [15:0] cmd_code_in;
	logic rd_valid_in;
	logic [2:0] rd_count_in;
	logic meas_done_in;
	logic [15:0] temp_in;
	logic [15:0] hum_in;
	logic busy_out;
	logic done_out;
	logic nack_out;
	logic [47:0] rx_data_out;
	logic meas_start_out;
	hrr_rep_t meas_rep_out;
	logic periodic_out;
	hrr_rate_t rate_out;
	logic result_valid_out;
	int bad_count = 0;
	int checks = 0;
	int lat = 300;
	int n_start = 0;
	int t_last = 0;
	int t_prev = 0;
	int cyc = 0;
	logic [15:0] exp_t;
	logic [15:0] exp_h;
	hrr_note_t notes[$];
	hrr_note_t wn;
	hrr_link_if hrr_link_if_i ();
	hrr_sensor #(.PERIOD_CYC(SIM_PERIOD)) hrr_sensor_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(hrr_link_if_i),
		.meas_done_in(meas_done_in), .temp_in(temp_in), .hum_in(hum_in), .meas_start_out(meas_start_out),
		.meas_rep_out(meas_rep_out), .periodic_out(periodic_out), .rate_out(rate_out),
		.result_valid_out(result_valid_out));
	hrr_master hrr_master_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(hrr_link_if_i), .cmd_valid_in(cmd_valid_in),
		.cmd_code_in(cmd_code_in), .rd_valid_in(rd_valid_in), .rd_count_in(rd_count_in), .busy_out(busy_out),
		.done_out(done_out), .nack_out(nack_out), .rx_data_out(rx_data_out));
	hrr_link_asserts hrr_link_asserts_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl(hrr_link_if_i.scl),
		.sda(hrr_link_if_i.sda), .dev_scl_oe(hrr_link_if_i.dev_scl_oe), .dev_sda_oe(hrr_link_if_i.dev_sda_oe));
	function automatic logic [7:0] crc(input logic [15:0] d);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	function automatic hrr_note_t rd_note(input logic [2:0] n);
		logic [47:0] b;
		b = {exp_t, crc(exp_t), exp_h, crc(exp_h)};
		return '{1'b0, n, b >> (8 * (6 - n))};
	endfunction
	function automatic logic [47:0] msk(input logic [2:0] n);
		return (48'h1 << (8 * n)) - 48'h1;
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic await(input int sel, input int lim);
		int k;
		k = 0;
		while ((sel == 0 ? result_valid_out !== 1'b1 : n_start < lim) && k < 4000) begin
			@(negedge clk_in);
			k++;
		end
		if (k == 4000) begin
			bad_count++;
			$display("wrong value wait exp event got timeout");
			give_verdict();
		end
	endtask
	// one request to the master end; the note is what its done should bring
	task automatic req(input logic iscmd, input logic [15:0] code, input hrr_note_t nt);
		int k;
		notes.push_back(nt);
		{cmd_valid_in, rd_valid_in, cmd_code_in, rd_count_in} = {iscmd, !iscmd, code, nt.n};
		@(negedge clk_in);
		{cmd_valid_in, rd_valid_in} = 2'h0;
		k = 0;
		while (busy_out !== 1'b0 && k < 20000) begin
			@(negedge clk_in);
			k++;
		end
		if (k == 20000) begin
			bad_count++;
			$display("wrong value busy exp 0 got 1");
			give_verdict();
		end
	endtask
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) cyc <= cyc + 1;
	// measurement responder: values drawn at start, presented with done after lat cycles
	initial begin
		{meas_done_in, temp_in, hum_in} = '0;
		forever begin
			@(negedge clk_in);
			if (meas_start_out === 1'b1) begin
				n_start++;
				t_prev = t_last;
				t_last = cyc;
				exp_t = 16'($urandom);
				exp_h = 16'($urandom);
				repeat (lat) @(negedge clk_in);
				{temp_in, hum_in, meas_done_in} = {exp_t, exp_h, 1'b1};
				@(negedge clk_in);
				meas_done_in = 1'b0;
			end
		end
	end
	always @(negedge clk_in) begin
		if (done_out === 1'b1) begin
			if (notes.size() == 0) `CHK("note", 1'b1, 1'b0)
			else begin
				wn = notes.pop_front();
				`CHK("nack", wn.nack, nack_out)
				if (!wn.nack) `CHK("rx", wn.d & msk(wn.n), rx_data_out & msk(wn.n))
			end
		end
	end
	initial begin
		hrr_note_t nt;
		logic [1:0] rep;
		void'($urandom(32'h0d10));
		{rst_n_in, cmd_valid_in, rd_valid_in, cmd_code_in, rd_count_in} = '0;
		repeat (10) @(negedge clk_in);
		rst_n_in = 1'b1;
		for (int i = 0; i < 6; i++) begin
			req(1'b1, (i < 3) ? {SS_STR_MSB, SS_STR_LSB[i]} : {SS_NOSTR_MSB, SS_NOSTR_LSB[i - 3]}, '0);
			`CHK("rep", hrr_rep_t'(i % 3), meas_rep_out)
			if (i < 3) req(1'b0, 16'h0000, rd_note(3'h6));
			else begin
				req(1'b0, 16'h0000, '{1'b1, 3'h6, 48'h0});
				await(0, 0);
				nt = rd_note(3'($urandom_range(6, 1)));
				req(1'b0, 16'h0000, nt);
			end
			`CHK("valid", 1'b0, result_valid_out)
			$display("single shot test %0d done", i);
		end
		lat = 20;
		for (int r = 0; r < 5; r++) begin
			rep = 2'($urandom_range(2, 0));
			req(1'b1, {PER_MSB[r], PER_LSB[r][rep]}, '0);
			await(1, n_start + 2);
			`CHK("periodic", 1'b1, periodic_out)
			`CHK("rate", hrr_rate_t'(r), rate_out)
			`CHK("rep", hrr_rep_t'(rep), meas_rep_out)
			`CHK("gap", 1'b1, ((t_last - t_prev) inside {[SIM_PERIOD[r] - 1 : SIM_PERIOD[r] + 1]}))
			req(1'b1, CMD_BREAK, '0);
			`CHK("periodic", 1'b0, periodic_out)
			await(0, 0);
			req(1'b0, 16'h0000, rd_note(3'h6));
			$display("periodic test %0d done", r);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
